// ---- hw/scan_if.sv ----
// Interface between the settings block and its scan pacing timer
`timescale 1ns/1ps
interface scan_if;
    logic run;
    logic [5:0] min_ms;
    logic scan_done;
    logic cycle_start;
    modport ctrl (output run, output min_ms, input cycle_start);
    modport timer (input run, input min_ms, input scan_done, output cycle_start);
endinterface : scan_if

// ---- hw/scan_pacer.sv ----
// Scan cycle pacer: starts a new cycle after both processing and the minimum time are done
`timescale 1ns/1ps
module scan_pacer
    import sys_settings_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic srst_in,
    scan_if.timer sif
);
    logic [16:0] tick_r;
    logic [5:0] ms_r;
    logic time_met;
    logic ms_tick;
    assign ms_tick = (tick_r == 17'(MS_CYCLES - 1));
    // Zero minimum means the cycle ends as soon as processing does
    assign time_met = (ms_r >= sif.min_ms);
    assign sif.cycle_start = sif.run && sif.scan_done && time_met; // RQ10 RQ12
    always_ff @(posedge sys_clk_in) begin
        if (srst_in || sif.cycle_start || !sif.run) begin
            tick_r <= '0;
            ms_r <= '0;
        end else if (ms_tick) begin
            tick_r <= '0;
            if (!time_met) begin
                ms_r <= ms_r + 6'h01;
            end
        end else begin
            tick_r <= tick_r + 17'h00001;
        end
    end
endmodule : scan_pacer

// ---- hw/sys_settings.sv ----
// System settings and startup mode controller with APB register access
// Notes on behaviour
// [RQ1] At power-up, run flag set and valid program present: enter RUN.
// [RQ2] At power-up, run flag cleared: stay in STOP.
// [RQ3] Run flag resets to set.
// [RQ4] Program delete and transfers leave the run flag unchanged.
// [RQ5] Without a program, never start in RUN.
// [RQ6] Display-less variant always starts in RUN, ignoring stored mode; code starts it in RUN only with a valid program.
// [RQ7] Card-boot set: start RUN only with a card holding a valid program.
// [RQ8] Card-boot with differing card program: copy it in, then RUN.
// [RQ9] Card-boot flag resets to cleared.
// [RQ10] Each scan cycle lasts at least the minimum time, longer if needed.
// [RQ11] Minimum cycle time accepts zero to sixty milliseconds.
// [RQ12] Zero minimum means scan as fast as possible; zero is default.
// [RQ13] Minimum cycle time changes only accepted in STOP.
// [RQ14] Debounce toggle command flips the enable; state is readable.
// [RQ15] Cursor-key input enable resets to disabled.
// [RQ16] Cursor keys drive inputs only while status screen shown; code also passes them on a text screen with no value entry.
// [RQ17] On a text screen, keys act only with no value entry.
// [RQ18] Delete clears key enable; program load applies carried enable.
// [RQ19] Retention resets off; only fixed groups selectable.
// [RQ20] Selected retentive items are saved at every power-off.
// [RQ21] Retentive group changes only accepted in STOP.
// [RQ22] Password-locked and not unlocked: settings access refused.
// [RQ23] Debounce enable resets to enabled.
// [RQ24] High-speed counter inputs bypass debounce.
// [RQ25] Startup decision samples its inputs once after reset release.
`timescale 1ns/1ps
module sys_settings
    import sys_settings_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic has_display_in,
    input wire logic prog_valid_in,
    input wire logic card_present_in,
    input wire logic card_valid_in,
    input wire logic card_differs_in,
    input wire logic copy_done_in,
    input wire logic locked_in,
    input wire logic status_screen_in,
    input wire logic text_screen_in,
    input wire logic value_entry_in,
    input wire logic [3:0] pkeys_in,
    input wire logic [7:0] inputs_raw_in,
    input wire logic [1:0] fast_count_raw_in,
    input wire logic scan_done_in,
    input wire logic power_fail_in,
    output logic [7:0] inputs_out,
    output logic [1:0] fast_count_out,
    output logic [3:0] pkey_inputs_out,
    output logic debounce_en_out,
    output logic run_mode_out,
    output logic copy_req_out,
    output logic cycle_start_out,
    output logic retain_save_out,
    output logic [sys_settings_pkg::RET_GROUPS-1:0] retain_sel_out
);
    import sys_settings_pkg::*;

    // Pins from the menu, card and power sense arrive asynchronously
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] async_pins;
    assign async_pins = {has_display_in, prog_valid_in, card_present_in, card_valid_in,
                         card_differs_in, copy_done_in, power_fail_in, locked_in};
    always_ff @(posedge sys_clk_in) begin
        sync1_r <= async_pins;
        sync2_r <= sync1_r;
    end
    logic s_display;
    logic s_prog_valid;
    logic s_card_present;
    logic s_card_valid;
    logic s_card_differs;
    logic s_copy_done;
    logic s_power_fail;
    logic s_locked;
    assign {s_display, s_prog_valid, s_card_present, s_card_valid,
            s_card_differs, s_copy_done, s_power_fail, s_locked} = sync2_r;

    logic [7:0] in1_r;
    logic [7:0] in2_r;
    logic [1:0] fc1_r;
    logic [1:0] fc2_r;
    logic [3:0] pk1_r;
    logic [3:0] pk2_r;
    always_ff @(posedge sys_clk_in) begin
        in1_r <= inputs_raw_in;
        in2_r <= in1_r;
        fc1_r <= fast_count_raw_in;
        fc2_r <= fc1_r;
        pk1_r <= pkeys_in;
        pk2_r <= pk1_r;
    end

    // Settings state
    logic debounce_r;
    logic pkeys_en_r;
    logic runflag_r;
    logic cardboot_r;
    logic [5:0] cycle_ms_r;
    logic [RET_GROUPS-1:0] retain_r;
    logic refused_r;
    mode_e mode_r;
    mode_e mode_nxt;

    // APB decode
    logic acc;
    logic wr;
    logic addr_ok;
    logic is_stop;
    logic wr_cycle;
    logic wr_retain;
    logic wr_cmd;
    logic wr_load;
    logic cycle_in_range;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        hit = (a == base);
    endfunction : hit
    assign acc = psel && penable;
    assign addr_ok = hit(paddr, ADDR_CTRL) || hit(paddr, ADDR_CYCLE) || hit(paddr, ADDR_RETAIN)
                     || hit(paddr, ADDR_STATUS) || hit(paddr, ADDR_CMD) || hit(paddr, ADDR_LOAD);
    assign wr = acc && pwrite && addr_ok && !s_locked; // RQ22
    assign is_stop = (mode_r == ST_STOP);
    assign cycle_in_range = (pwdata[5:0] <= 6'(CYCLE_MS_MAX)) && (pwdata[31:6] == 26'h0000000); // RQ11
    assign wr_cycle = wr && hit(paddr, ADDR_CYCLE) && is_stop && cycle_in_range; // RQ13
    assign wr_retain = wr && hit(paddr, ADDR_RETAIN) && is_stop; // RQ21
    assign wr_cmd = wr && hit(paddr, ADDR_CMD);
    assign wr_load = wr && hit(paddr, ADDR_LOAD) && is_stop;
    assign pready = 1'b1;
    // Refused writes show as an error so software learns the setting did not take
    assign pslverr = acc && (!addr_ok || (pwrite && s_locked)
                     || (pwrite && hit(paddr, ADDR_CYCLE) && (!is_stop || !cycle_in_range))
                     || (pwrite && (hit(paddr, ADDR_RETAIN) || hit(paddr, ADDR_LOAD)) && !is_stop));

    logic cmd_delete;
    assign cmd_delete = wr_cmd && pwdata[CMD_DELETE_BIT] && is_stop;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            debounce_r <= RST_DEBOUNCE; // RQ23
            pkeys_en_r <= RST_PKEYS; // RQ15
            runflag_r <= RST_RUNFLAG; // RQ3
            cardboot_r <= RST_CARDBOOT; // RQ9
        end else begin
            if (wr_cmd && pwdata[CMD_TOG_DEBOUNCE_BIT]) begin
                debounce_r <= !debounce_r; // RQ14
            end
            // Delete and loads never touch the run flag
            if (wr_cmd && pwdata[CMD_TOG_RUNFLAG_BIT]) begin
                runflag_r <= !runflag_r; // RQ4
            end
            if (wr_cmd && pwdata[CMD_TOG_CARDBOOT_BIT]) begin
                cardboot_r <= !cardboot_r;
            end
            if (cmd_delete) begin
                pkeys_en_r <= 1'b0; // RQ18
            end else if (wr_load) begin
                pkeys_en_r <= pwdata[LOAD_PKEYS_BIT]; // RQ18
            end else if (wr_cmd && pwdata[CMD_TOG_PKEYS_BIT]) begin
                pkeys_en_r <= !pkeys_en_r;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cycle_ms_r <= RST_CYCLE_MS; // RQ12
            retain_r <= RST_RETAIN; // RQ19
            refused_r <= 1'b0;
        end else begin
            if (wr_cycle) begin
                cycle_ms_r <= pwdata[5:0];
            end
            if (cmd_delete) begin
                retain_r <= RST_RETAIN;
            end else if (wr_load) begin
                retain_r <= pwdata[LOAD_RETAIN_LSB +: RET_GROUPS];
            end else if (wr_retain) begin
                retain_r <= pwdata[RET_GROUPS-1:0]; // RQ19
            end
            if (acc && pwrite && s_locked) begin
                refused_r <= 1'b1; // RQ22
            end else if (wr_cmd) begin
                refused_r <= 1'b0;
            end
        end
    end

    // Startup decision, taken once after the synchronisers have settled
    logic [1:0] settle_r;
    logic settled;
    logic start_run;
    logic start_copy;
    logic card_ok;
    assign settled = (settle_r == 2'h3);
    assign card_ok = s_card_present && s_card_valid;
    assign start_copy = cardboot_r && card_ok && s_card_differs; // RQ8
    assign start_run = !s_display ? s_prog_valid // RQ6
                     : cardboot_r ? card_ok // RQ7
                     : (runflag_r && s_prog_valid); // RQ1 RQ2 RQ5

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            ST_RESET: begin
                if (settled) begin
                    mode_nxt = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                if (start_copy) begin
                    mode_nxt = ST_COPY;
                end else if (start_run) begin
                    mode_nxt = ST_RUN;
                end else begin
                    mode_nxt = ST_STOP;
                end
            end
            ST_COPY: begin
                if (s_copy_done) begin
                    mode_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wr_cmd && pwdata[CMD_GO_STOP_BIT]) begin
                    mode_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                if (wr_cmd && pwdata[CMD_GO_RUN_BIT] && s_prog_valid && !cmd_delete) begin
                    mode_nxt = ST_RUN;
                end
            end
            default: begin
                mode_nxt = ST_STOP;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mode_r <= ST_RESET;
            settle_r <= 2'h0;
        end else begin
            mode_r <= mode_nxt; // RQ25
            if (!settled) begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end
    // Pacer for the minimum scan time
    scan_if sif ();
    assign sif.run = (mode_r == ST_RUN);
    assign sif.min_ms = cycle_ms_r;
    assign sif.scan_done = scan_done_in;
    scan_pacer u_pacer (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .sif(sif)
    );

    // Input path: debounce is a two-sample agreement; fast counters never pass through it
    logic [7:0] prev_in_r;
    logic [7:0] inputs_r;
    logic [1:0] fast_r;
    logic [3:0] pkout_r;
    logic pkeys_live;
    assign pkeys_live = pkeys_en_r && (status_screen_in || (text_screen_in && !value_entry_in)); // RQ16 RQ17
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            prev_in_r <= 8'h00;
            inputs_r <= 8'h00;
            fast_r <= 2'h0;
            pkout_r <= 4'h0;
        end else begin
            prev_in_r <= in2_r;
            inputs_r <= debounce_r ? ((in2_r & prev_in_r) | (inputs_r & (in2_r | prev_in_r))) : in2_r;
            fast_r <= fc2_r; // RQ24
            pkout_r <= pkeys_live ? pk2_r : 4'h0;
        end
    end

    // Power-fail edge requests a save of the selected groups
    logic pf_prev_r;
    logic save_r;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pf_prev_r <= 1'b0;
            save_r <= 1'b0;
        end else begin
            pf_prev_r <= s_power_fail;
            save_r <= s_power_fail && !pf_prev_r && (retain_r != RST_RETAIN); // RQ20
        end
    end

    // Read mux
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h00000000;
        if (hit(paddr, ADDR_CTRL)) begin
            rd_data[CTRL_DEBOUNCE_BIT] = debounce_r;
            rd_data[CTRL_PKEYS_BIT] = pkeys_en_r;
            rd_data[CTRL_RUNFLAG_BIT] = runflag_r;
            rd_data[CTRL_CARDBOOT_BIT] = cardboot_r;
        end else if (hit(paddr, ADDR_CYCLE)) begin
            rd_data[5:0] = cycle_ms_r;
        end else if (hit(paddr, ADDR_RETAIN)) begin
            rd_data[RET_GROUPS-1:0] = retain_r;
        end else if (hit(paddr, ADDR_STATUS)) begin
            rd_data[STAT_RUN_BIT] = (mode_r == ST_RUN);
            rd_data[STAT_COPY_BIT] = (mode_r == ST_COPY);
            rd_data[STAT_DECIDED_BIT] = (mode_r != ST_RESET) && (mode_r != ST_DECIDE);
            rd_data[STAT_REFUSED_BIT] = refused_r;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_data;
        end
    end

    assign inputs_out = inputs_r;
    assign fast_count_out = fast_r;
    assign pkey_inputs_out = pkout_r;
    assign debounce_en_out = debounce_r;
    assign run_mode_out = (mode_r == ST_RUN);
    assign copy_req_out = (mode_r == ST_COPY);
    assign cycle_start_out = sif.cycle_start;
    assign retain_save_out = save_r;
    assign retain_sel_out = retain_r;
    // Checks
    a_cycle_stop_only: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !is_stop |=> $stable(cycle_ms_r)) else $error("cycle time changed outside STOP"); // RQ13
    a_cycle_range: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        cycle_ms_r <= 6'(CYCLE_MS_MAX)) else $error("cycle time above limit"); // RQ11
    a_retain_stop_only: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !is_stop |=> $stable(retain_r)) else $error("retention changed outside STOP"); // RQ21
    a_no_prog_no_run: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (mode_r == ST_DECIDE && !s_prog_valid && !start_copy && (s_display ? !cardboot_r : 1'b1))
        |=> mode_r == ST_STOP) else $error("started RUN without program"); // RQ5
    a_runflag_clear_stop: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (mode_r == ST_DECIDE && s_display && !cardboot_r && !runflag_r) |=> mode_r == ST_STOP)
        else $error("run flag clear but not STOP"); // RQ2
    sequence copy_then_run;
        (mode_r == ST_COPY) ##1 (mode_r == ST_COPY || mode_r == ST_RUN);
    endsequence
    a_card_copy: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (mode_r == ST_DECIDE && start_copy) |=> copy_then_run) else $error("card copy sequence broken"); // RQ8
    a_pkeys_gate: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (!pkeys_en_r || (!status_screen_in && !text_screen_in)) |=> pkey_inputs_out == 4'h0)
        else $error("cursor keys leaked"); // RQ16
    a_locked_refuse: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (acc && pwrite && s_locked) |=> $stable(debounce_r) && $stable(runflag_r) && refused_r)
        else $error("locked write accepted"); // RQ22
    a_delete_clears: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        cmd_delete |=> !pkeys_en_r && $stable(runflag_r)) else $error("delete effect wrong"); // RQ18
endmodule : sys_settings

// ---- hw/sys_settings_pkg.sv ----
// Package: register map, field layout, reset values and timing for the system settings block
package sys_settings_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CYCLE = 8'h04;
    localparam logic [7:0] ADDR_RETAIN = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_LOAD = 8'h14;
    // CTRL fields
    localparam int CTRL_DEBOUNCE_BIT = 0;
    localparam int CTRL_PKEYS_BIT = 1;
    localparam int CTRL_RUNFLAG_BIT = 2;
    localparam int CTRL_CARDBOOT_BIT = 3;
    // CMD fields (write-one pulses)
    localparam int CMD_TOG_DEBOUNCE_BIT = 0;
    localparam int CMD_TOG_PKEYS_BIT = 1;
    localparam int CMD_TOG_RUNFLAG_BIT = 2;
    localparam int CMD_TOG_CARDBOOT_BIT = 3;
    localparam int CMD_DELETE_BIT = 4;
    localparam int CMD_GO_RUN_BIT = 5;
    localparam int CMD_GO_STOP_BIT = 6;
    // LOAD fields: program transfer from card or PC
    localparam int LOAD_PKEYS_BIT = 0;
    localparam int LOAD_RETAIN_LSB = 8;
    // STATUS fields
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_COPY_BIT = 1;
    localparam int STAT_DECIDED_BIT = 2;
    localparam int STAT_REFUSED_BIT = 3;
    // Retentive groups
    localparam int RET_GROUPS = 7;
    localparam int RET_MARKER_A = 0;
    localparam int RET_MARKER_B = 1;
    localparam int RET_MARKER_C = 2;
    localparam int RET_COUNTER_A = 3;
    localparam int RET_FAST_COUNTER = 4;
    localparam int RET_TEXT_RELAY = 5;
    localparam int RET_TIMER_B = 6;
    // Reset values
    localparam logic RST_DEBOUNCE = 1'b1;
    localparam logic RST_PKEYS = 1'b0;
    localparam logic RST_RUNFLAG = 1'b1;
    localparam logic RST_CARDBOOT = 1'b0;
    localparam logic [5:0] RST_CYCLE_MS = 6'h00;
    localparam logic [RET_GROUPS-1:0] RST_RETAIN = 7'h00;
    // Timing
    localparam int CYCLE_MS_MAX = 60;
    localparam int CLK_MHZ = 100;
    localparam int MS_CYCLES = CLK_MHZ * 1000;
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_DECIDE = 3'b001,
        ST_COPY = 3'b010,
        ST_RUN = 3'b011,
        ST_STOP = 3'b100
    } mode_e;
endpackage : sys_settings_pkg

// ---- verif/sys_settings_tb.sv ----
// Self-checking testbench for the system settings and startup controller
`timescale 1ns/1ps
module sys_settings_tb;
    import sys_settings_pkg::*;
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic has_display_in = 1'b1;
    logic prog_valid_in = 1'b1;
    logic card_present_in = 1'b0;
    logic card_valid_in = 1'b0;
    logic card_differs_in = 1'b0;
    logic copy_done_in = 1'b0;
    logic locked_in = 1'b0;
    logic status_screen_in = 1'b0;
    logic text_screen_in = 1'b0;
    logic value_entry_in = 1'b0;
    logic [3:0] pkeys_in = 4'h0;
    logic [7:0] inputs_raw_in = 8'h00;
    logic [1:0] fast_count_raw_in = 2'h0;
    logic scan_done_in = 1'b0;
    logic power_fail_in = 1'b0;
    logic [7:0] inputs_out;
    logic [1:0] fast_count_out;
    logic [3:0] pkey_inputs_out;
    logic debounce_en_out;
    logic run_mode_out;
    logic copy_req_out;
    logic cycle_start_out;
    logic retain_save_out;
    logic [RET_GROUPS-1:0] retain_sel_out;
    logic [31:0] seed = 32'h84bfab80;
    logic [31:0] rd;
    logic [31:0] v;
    logic er;
    logic hit;
    logic [2:0] scr [4] = '{3'b100, 3'b011, 3'b010, 3'b000};
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    sys_settings i_dut (.sys_clk_in, .srst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .has_display_in, .prog_valid_in, .card_present_in, .card_valid_in, .card_differs_in,
        .copy_done_in, .locked_in, .status_screen_in, .text_screen_in, .value_entry_in, .pkeys_in,
        .inputs_raw_in, .fast_count_raw_in, .scan_done_in, .power_fail_in, .inputs_out, .fast_count_out,
        .pkey_inputs_out, .debounce_en_out, .run_mode_out, .copy_req_out, .cycle_start_out,
        .retain_save_out, .retain_sel_out);

    always #5 sys_clk_in = ~sys_clk_in;

    // Whole run needs a few hundred cycles; the ceiling leaves wide margin
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Keys reach the program on the status screen, or on a text screen with no entry open
    function automatic logic key_gate(input logic [2:0] s);
        return s[2] | (s[1] & ~s[0]);
    endfunction : key_gate

    task automatic test_done();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : wait_cyc

    // Values read right after the edge are the ones the slave presented at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic watch(input int which, input int n);
        hit = 1'b0;
        repeat (n) begin
            @(posedge sys_clk_in);
            if (which == 0 && cycle_start_out === 1'b1) hit = 1'b1;
            if (which == 1 && retain_save_out === 1'b1) hit = 1'b1;
        end
    endtask : watch

    // Straps must be steady before release, since the decision is taken once afterwards
    task automatic rst();
        srst_in <= 1'b1;
        wait_cyc(12);
        srst_in <= 1'b0;
        wait_cyc(10);
    endtask : rst

    // The command lands two edges before the startup decision falls due
    task automatic rst_cmd(input logic [31:0] cmd);
        srst_in <= 1'b1;
        wait_cyc(12);
        srst_in <= 1'b0;
        wr(ADDR_CMD, cmd);
        wait_cyc(8);
    endtask : rst_cmd

    initial begin
        rst();
        chk(run_mode_out, 1'b1);
        chk(debounce_en_out, 1'b1);
        chk(retain_sel_out, 7'h00);
        rdchk(ADDR_CTRL, 32'h5);
        rdchk(ADDR_CYCLE, 32'h0);
        rdchk(ADDR_RETAIN, 32'h0);
        rdchk(ADDR_STATUS, 32'h5);
        scan_done_in <= 1'b1;
        watch(0, 20);
        chk(hit, 1'b1);
        wr(ADDR_CYCLE, 32'h5);
        chk(er, 1'b1);
        rdchk(ADDR_CYCLE, 32'h0);
        wr(ADDR_RETAIN, 32'h7f);
        chk(er, 1'b1);
        rdchk(ADDR_RETAIN, 32'h0);
        prog_valid_in <= 1'b0;
        wait_cyc(6);
        chk(run_mode_out, 1'b1);
        prog_valid_in <= 1'b1;
        wr(ADDR_CMD, 32'h1 << CMD_GO_STOP_BIT);
        wait_cyc(3);
        watch(0, 20);
        chk(hit, 1'b0);
        wr(ADDR_CYCLE, 32'd60);
        chk(er, 1'b0);
        rdchk(ADDR_CYCLE, 32'd60);
        wr(ADDR_CYCLE, 32'd61);
        chk(er, 1'b1);
        rdchk(ADDR_CYCLE, 32'd60);
        wr(ADDR_CMD, 32'h1 << CMD_GO_RUN_BIT);
        watch(0, 50);
        chk(hit, 1'b0);
        chk(run_mode_out, 1'b1);
        wr(ADDR_CMD, 32'h1 << CMD_GO_STOP_BIT);
        wr(ADDR_CYCLE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = xs();
            wr(ADDR_RETAIN, v);
            chk(er, 1'b0);
            rdchk(ADDR_RETAIN, {25'h0, v[6:0]});
            inputs_raw_in <= v[15:8];
            fast_count_raw_in <= v[17:16];
            wait_cyc(8);
            chk(retain_sel_out, v[6:0]);
            chk(inputs_out, v[15:8]);
            chk(fast_count_out, v[17:16]);
        end
        wr(ADDR_RETAIN, 32'h41);
        power_fail_in <= 1'b1;
        watch(1, 10);
        chk(hit, 1'b1);
        power_fail_in <= 1'b0;
        wr(ADDR_CMD, 32'h1 << CMD_TOG_DEBOUNCE_BIT);
        wait_cyc(3);
        chk(debounce_en_out, 1'b0);
        rdchk(ADDR_CTRL, 32'h4);
        v = xs();
        inputs_raw_in <= v[7:0];
        fast_count_raw_in <= v[9:8];
        wait_cyc(6);
        chk(inputs_out, v[7:0]);
        chk(fast_count_out, v[9:8]);
        wr(ADDR_CMD, 32'h1 << CMD_TOG_DEBOUNCE_BIT);
        wait_cyc(3);
        chk(debounce_en_out, 1'b1);
        status_screen_in <= 1'b1;
        pkeys_in <= 4'h5;
        wait_cyc(6);
        chk(pkey_inputs_out, 4'h0);
        wr(ADDR_CMD, 32'h1 << CMD_TOG_PKEYS_BIT);
        for (int i = 0; i < 4; i++) begin
            v = xs();
            {status_screen_in, text_screen_in, value_entry_in} <= scr[i];
            pkeys_in <= v[3:0] | 4'h1;
            wait_cyc(6);
            chk(pkey_inputs_out, key_gate(scr[i]) ? (v[3:0] | 4'h1) : 4'h0);
        end
        wr(ADDR_CMD, 32'h1 << CMD_DELETE_BIT);
        rdchk(ADDR_CTRL, 32'h5);
        rdchk(ADDR_RETAIN, 32'h0);
        v = xs();
        wr(ADDR_LOAD, {17'h0, v[6:0], 8'h01});
        rdchk(ADDR_CTRL, 32'h7);
        rdchk(ADDR_RETAIN, {25'h0, v[6:0]});
        locked_in <= 1'b1;
        wait_cyc(4);
        wr(ADDR_CYCLE, 32'h7);
        chk(er, 1'b1);
        rdchk(ADDR_STATUS, 32'hc);
        rdchk(ADDR_CYCLE, 32'h0);
        locked_in <= 1'b0;
        wait_cyc(4);
        wr(ADDR_CMD, 32'h0);
        rdchk(ADDR_STATUS, 32'h4);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        for (int i = 0; i < 4; i++) begin
            v = xs();
            has_display_in <= i[0];
            prog_valid_in <= i[1];
            card_present_in <= v[0];
            rst();
            chk(run_mode_out, i[1]);
        end
        has_display_in <= 1'b0;
        prog_valid_in <= 1'b1;
        rst_cmd(32'h1 << CMD_TOG_RUNFLAG_BIT);
        chk(run_mode_out, 1'b1);
        has_display_in <= 1'b1;
        rst_cmd(32'h1 << CMD_TOG_RUNFLAG_BIT);
        chk(run_mode_out, 1'b0);
        card_present_in <= 1'b0;
        rst_cmd(32'h1 << CMD_TOG_CARDBOOT_BIT);
        chk(run_mode_out, 1'b0);
        card_present_in <= 1'b1;
        card_valid_in <= 1'b1;
        rst_cmd(32'h1 << CMD_TOG_CARDBOOT_BIT);
        chk(run_mode_out, 1'b1);
        card_differs_in <= 1'b1;
        rst_cmd(32'h1 << CMD_TOG_CARDBOOT_BIT);
        chk(copy_req_out, 1'b1);
        chk(run_mode_out, 1'b0);
        rdchk(ADDR_STATUS, 32'h6);
        copy_done_in <= 1'b1;
        wait_cyc(5);
        chk(run_mode_out, 1'b1);
        chk(copy_req_out, 1'b0);
        test_done();
    end
endmodule : sys_settings_tb
